// ### dv/dct_props.sv
// concurrent checks on the register bus and device status outputs
`timescale 1ns/1ps
module dct_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire logic [5:0] addr,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [7:0] wdata,
   // device side
   input wire logic [1:0] txFillOk,
   input wire logic [1:0] txWrite,
   input wire logic [1:0] txOff,
   input wire logic [1:0] breakEdge,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe,
   input wire logic [7:0] intBid,
   input wire logic [7:0] intStatus
);
   logic [7:0] mask_r;
   logic [7:0] aux_r;
   logic oeSet_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==================================================================
   // shadows of what the host wrote; pair zero only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_r <= 8'h00;
         aux_r <= 8'h00;
         oeSet_r <= 1'h0;
      end else if (wrEn) begin
         if (addr == 6'h05) mask_r <= wdata;
         if (addr == 6'h08) aux_r <= wdata;
         if (addr == 6'h0B) oeSet_r <= 1'h1;
      end
   end
   // ==================================================================
   // assertions
   chk_bid_masked: assert property (intBid == (intStatus & mask_r))
      else $error("bid differs from status and mask");
   chk_pins_input: assert property (!oeSet_r |-> ioOe == 4'h0)
      else $error("pin driven before direction write");
   chk_tx_clear: assert property (txWrite[0] |=> !intStatus[0])
      else $error("tx ready kept over queue write");
   chk_tx_return: assert property (txWrite[0] && txFillOk[0] && !txOff[0] ##1
      (txFillOk[0] && !txOff[0] && !txWrite[0]) [*2] |-> ##[0:1] intStatus[0])
      else $error("tx ready not back within two clocks");
   chk_tx_level: assert property ((txOff[0] || !txFillOk[0]) [*3] |-> !intStatus[0])
      else $error("tx ready set while not eligible");
   chk_brk_set: assert property (breakEdge[0] |-> ##[1:2] intStatus[2])
      else $error("break change not flagged");
   chk_brk_hold: assert property (intStatus[2] && !(wrEn && addr == 6'h0A && wdata[0])
      |=> intStatus[2])
      else $error("break change lost without command");
   chk_stop_ready: assert property (rdEn && addr == 6'h0F |=> !intStatus[3])
      else $error("stop left counter ready set");
   chk_stop_out: assert property (rdEn && addr == 6'h0F && !aux_r[6] |=> ioOut[3])
      else $error("stop left counter output low");
   chk_change_clear: assert property (rdEn && addr == 6'h09 |=> !intStatus[7])
      else $error("change status kept after read");
   // main scenarios reached
   cov_stop: cover property (rdEn && addr == 6'h0F);
   cov_change: cover property (rdEn && addr == 6'h09);
   cov_brk: cover property (breakEdge[0]);
endmodule

// ### dv/duart_ct_intstatus_cos_test.sv
// self-checking bench joining host controller and device end
`timescale 1ns/1ps
module duart_ct_intstatus_cos_test;
   typedef struct packed {
      logic [1:0] fill;
      logic [1:0] off;
      logic [1:0] rx;
      logic [7:0] mask;
      logic [7:0] st;
      logic [7:0] bid;
   } dct_row_t;
   logic clk, rst, awValid, awReady, wValid, wReady, bValid, bReady;
   logic arValid, arReady, rValid, rReady;
   logic [3:0] awAddr, arAddr, pinDrv, ioIn, ioOut, ioOe;
   logic [31:0] wData, rData, s;
   logic [1:0] bResp, rResp, txFillOk, txWrite, txOff, rxReady, breakEdge, txClk;
   logic [7:0] intBid, intStatus;
   int fail_count, check_count, p;
   // status word = tx a bit0, rx a bit1, tx b bit4, rx b bit5
   dct_row_t rows [4] = '{'{2'h3, 2'h0, 2'h0, 8'hFF, 8'h11, 8'h11},
      '{2'h1, 2'h1, 2'h2, 8'h20, 8'h20, 8'h20}, '{2'h2, 2'h0, 2'h1, 8'h01, 8'h12, 8'h00},
      '{2'h0, 2'h3, 2'h3, 8'h02, 8'h22, 8'h02}};
   dct_bus_if busIf();
   // pin level is the driver's own value while the device drives it
   assign ioIn = (ioOe & ioOut) | (~ioOe & pinDrv);
   dct_host dct_host_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .bus(busIf));
   dct_device dct_device_inst (.clk(clk), .rst(rst), .bus(busIf), .txFillOk(txFillOk),
      .txWrite(txWrite), .txOff(txOff), .rxReady(rxReady), .breakEdge(breakEdge),
      .txClkA(txClk[0]), .txClkB(txClk[1]), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
      .intBid(intBid), .intStatus(intStatus));
   dct_props dct_props_inst (.clk(clk), .rst(rst), .addr(busIf.addr), .wrEn(busIf.wrEn),
      .rdEn(busIf.rdEn), .wdata(busIf.wdata), .txFillOk(txFillOk), .txWrite(txWrite),
      .txOff(txOff), .breakEdge(breakEdge), .ioOut(ioOut), .ioOe(ioOe), .intBid(intBid),
      .intStatus(intStatus));
   // ==================================================================
   // shared tasks
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // address and data offered together, each released once taken
   task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
      logic da, dw;
      da = 1'h0;
      dw = 1'h0;
      awAddr <= a;
      wData <= d;
      awValid <= 1'h1;
      wValid <= 1'h1;
      bReady <= 1'h1;
      forever begin
         @(posedge clk);
         if (!da && awReady === 1'h1) begin
            da = 1'h1;
            awValid <= 1'h0;
         end
         if (!dw && wReady === 1'h1) begin
            dw = 1'h1;
            wValid <= 1'h0;
         end
         if (bValid === 1'h1) begin
            bReady <= 1'h0;
            break;
         end
      end
   endtask
   task automatic axiRd(input logic [3:0] a, output logic [31:0] d);
      logic da;
      da = 1'h0;
      arAddr <= a;
      arValid <= 1'h1;
      rReady <= 1'h1;
      forever begin
         @(posedge clk);
         if (!da && arReady === 1'h1) begin
            da = 1'h1;
            arValid <= 1'h0;
         end
         if (rValid === 1'h1) begin
            d = rData;
            rReady <= 1'h0;
            break;
         end
      end
   endtask
   // one device access through the command word, then wait for not busy
   task automatic busCmd(input logic wr, input logic [5:0] a, input logic [7:0] d,
      output logic [31:0] st);
      axiWr(4'h0, {16'h0000, wr, 1'h0, a, d});
      do begin
         axiRd(4'h4, st);
         // let an edge pass so rready is not lowered and raised in one step
         if (st[8] === 1'h1) @(posedge clk);
      end while (st[8] === 1'h1);
   endtask
   task automatic period(output int cyc);
      time t;
      @(posedge ioOut[3]);
      t = $time;
      @(posedge ioOut[3]);
      cyc = int'(($time - t) / 50);
      @(posedge clk);
   endtask
   // ==================================================================
   // clock and watchdog
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   initial begin
      #(20000 * 50);
      fail_count++;
      summarize();
   end
   // ==================================================================
   // main sequence
   initial begin
      {rst, awValid, wValid, bReady, arValid, rReady} = 6'h20;
      {awAddr, arAddr, wData, pinDrv} = '0;
      {txFillOk, txWrite, txOff, rxReady, breakEdge, txClk} = '0;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      check("ioOe", {4'h0, ioOe}, 8'h00);
      check("ioOut", {4'h0, ioOut}, 8'h0F);
      check("ready", {7'h0, intStatus[3]}, 8'h00);
      // ordinary status and mask cases
      foreach (rows[i]) begin
         {txFillOk, txOff, rxReady} <= {rows[i].fill, rows[i].off, rows[i].rx};
         busCmd(1'h1, 6'h05, rows[i].mask, s);
         busCmd(1'h0, 6'h04, 8'h00, s);
         check("status", s[7:0], rows[i].st);
         check("bid", intBid, rows[i].bid);
      end
      // queue write drops tx ready, back two clocks later
      {txFillOk, txOff} <= 4'hC;
      repeat (3) @(posedge clk);
      txWrite <= 2'h1;
      @(posedge clk);
      txWrite <= 2'h0;
      @(posedge clk);
      check("txCleared", {7'h0, intStatus[0]}, 8'h00);
      repeat (3) @(posedge clk);
      check("txBack", {7'h0, intStatus[0]}, 8'h01);
      // break change held until its own command
      breakEdge <= 2'h1;
      @(posedge clk);
      breakEdge <= 2'h0;
      repeat (4) @(posedge clk);
      check("brk", {7'h0, intStatus[2]}, 8'h01);
      busCmd(1'h1, 6'h0A, 8'h02, s);
      check("brkOther", {7'h0, intStatus[2]}, 8'h01);
      busCmd(1'h1, 6'h0A, 8'h01, s);
      check("brkCleared", {7'h0, intStatus[2]}, 8'h00);
      // counter mode on X1/16, preset 3; preset 1 is refused
      busCmd(1'h1, 6'h08, 8'h30, s);
      busCmd(1'h1, 6'h06, 8'h00, s);
      busCmd(1'h1, 6'h07, 8'h01, s);
      check("refused", {7'h0, s[9]}, 8'h01);
      busCmd(1'h1, 6'h07, 8'h03, s);
      busCmd(1'h0, 6'h0E, 8'h00, s);
      repeat (15) @(posedge clk);
      check("early", {6'h0, intStatus[3], ioOut[3]}, 8'h01);
      repeat (60) @(posedge clk);
      check("terminal", {6'h0, intStatus[3], ioOut[3]}, 8'h02);
      busCmd(1'h1, 6'h07, 8'h40, s);
      busCmd(1'h0, 6'h06, 8'h00, s);
      check("wrapped", s[7:0], 8'hFF);
      busCmd(1'h0, 6'h0F, 8'h00, s);
      check("stopped", {6'h0, intStatus[3], ioOut[3]}, 8'h01);
      busCmd(1'h0, 6'h0E, 8'h00, s);
      busCmd(1'h0, 6'h06, 8'h00, s);
      check("newPreset", s[7:0], 8'h00);
      // timer mode on X1, preset 0x40: period 128 clocks
      busCmd(1'h1, 6'h08, 8'h60, s);
      busCmd(1'h0, 6'h0E, 8'h00, s);
      period(p);
      check("period", 8'(p), 8'h80);
      check("timerReady", {7'h0, intStatus[3]}, 8'h01);
      busCmd(1'h0, 6'h0F, 8'h00, s);
      check("timerStop", {7'h0, intStatus[3]}, 8'h00);
      period(p);
      check("running", 8'(p), 8'h80);
      // counter clocked by channel a transmit clock pulses, preset 3
      busCmd(1'h1, 6'h08, 8'h10, s);
      busCmd(1'h0, 6'h0F, 8'h00, s);
      busCmd(1'h1, 6'h07, 8'h03, s);
      busCmd(1'h0, 6'h0E, 8'h00, s);
      repeat (3) begin
         txClk <= 2'h1;
         @(posedge clk);
         txClk <= 2'h0;
         @(posedge clk);
      end
      check("txClkCount", {6'h0, intStatus[3], ioOut[3]}, 8'h02);
      // change detect on io0a, io1b driven by the counter output
      busCmd(1'h1, 6'h08, 8'h01, s);
      busCmd(1'h0, 6'h0F, 8'h00, s);
      busCmd(1'h1, 6'h0B, 8'h08, s);
      check("pinOe", {4'h0, ioOe}, 8'h08);
      pinDrv <= 4'h1;
      repeat (400) @(posedge clk);
      check("notYet", {7'h0, intStatus[7]}, 8'h00);
      repeat (1300) @(posedge clk);
      check("changeSt", {7'h0, intStatus[7]}, 8'h01);
      busCmd(1'h0, 6'h09, 8'h00, s);
      check("change", s[7:0], 8'h99);
      check("changeClr", {7'h0, intStatus[7]}, 8'h00);
      busCmd(1'h0, 6'h09, 8'h00, s);
      check("changeAgain", s[7:0], 8'h09);
      // mid-run reset must return the driven pin to input
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      check("rstOe", {4'h0, ioOe}, 8'h00);
      summarize();
   end
endmodule

// ### verilog/dct_bus_if.sv
// parallel register bus between host controller and counter/status block
`timescale 1ns/1ps
interface dct_bus_if;
   logic [5:0] addr;
   logic wrEn;
   logic rdEn;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport dev (input addr, input wrEn, input rdEn, input wdata, output rdata);
   modport host (output addr, output wrEn, output rdEn, output wdata, input rdata);
endinterface

// ### verilog/dct_defs.svh
// register offsets, field positions, reset values and timing counts of the counter/status block
`ifndef DCT_DEFS_SVH
`define DCT_DEFS_SVH
// ==================================================================
// device register offsets (low nibble, addr[4] picks the pair)
`define DCT_OFS_STATUS 4'h4
`define DCT_OFS_MASK 4'h5
`define DCT_OFS_PRESET_HI 4'h6
`define DCT_OFS_PRESET_LO 4'h7
`define DCT_OFS_AUX 4'h8
`define DCT_OFS_CHANGE 4'h9
`define DCT_OFS_CMD 4'hA
`define DCT_OFS_PINOE 4'hB
`define DCT_OFS_START 4'hE
`define DCT_OFS_STOP 4'hF
// ==================================================================
// status bit positions
`define DCT_ST_TXA 0
`define DCT_ST_RXA 1
`define DCT_ST_BRKA 2
`define DCT_ST_CTR 3
`define DCT_ST_TXB 4
`define DCT_ST_RXB 5
`define DCT_ST_BRKB 6
`define DCT_ST_COS 7
// ==================================================================
// reset values and the smallest accepted preset
`define DCT_RST_PRESET_HI 8'h00
`define DCT_RST_PRESET_LO 8'h02
`define DCT_RST_MASK 8'h00
`define DCT_RST_AUX 8'h00
`define DCT_MIN_PRESET 8'h02
// ==================================================================
// timing: clock rate and change detector sample rate, in Hz
`define DCT_CLK_HZ 20000000
`define DCT_COS_HZ 38400
`define DCT_COS_DIV ((`DCT_CLK_HZ + `DCT_COS_HZ / 2) / `DCT_COS_HZ)
// ==================================================================
// host controller registers (AXI4-Lite byte offsets)
`define DCT_HOFS_CMD 4'h0
`define DCT_HOFS_STAT 4'h4
`define DCT_HCMD_WR 15
`define DCT_RESP_OKAY 2'h0
`define DCT_RESP_SLVERR 2'h2
`endif

// ### verilog/dct_device.sv
// counter/timer, interrupt status and change detectors of one channel pair
// Functional notes
// - tx ready follows empty-slot level, off clears
// - fifo write clears tx ready, resets within two
// - status bits: txb4 ctr3 brka2 rxa1 txa0
// - counter mode: ready at terminal, stop clears
// - timer mode: ready per cycle, stop clears only
// - break change sets on edge, command clears
// - bid needs status and mask; reads unmasked
// - preset bytes write-only; low byte under two refused after zero high byte
// - square period twice preset; half-period kept
// - start read restarts timer or counter
// - stop read is the stop command
// - counter counts down, flags zero, wraps
// - counter pin high until terminal, stop restores
// - counter uses new preset only at next start; timer reloads it each half-period
// - live count readable as two bytes
// - pin inputs follow level even when driven
// - all four pins are inputs after reset
// - two pins per channel latch changes
// - changes confirmed over two 38.4 kHz samples
// - change register read clears change flags
// - change register: flags high, levels low
// - enable field gates flags into status
// - mode field selects mode and clock
`timescale 1ns/1ps
`include "dct_defs.svh"
module dct_device #(
   parameter logic PAIR = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   dct_bus_if.dev bus,
   // channel fifo and receiver inputs, a at bit 0
   input wire logic [1:0] txFillOk,
   input wire logic [1:0] txWrite,
   input wire logic [1:0] txOff,
   input wire logic [1:0] rxReady,
   input wire logic [1:0] breakEdge,
   input wire logic txClkA,
   input wire logic txClkB,
   // io pins: 0 = io0a, 1 = io1a, 2 = io0b, 3 = io1b
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   // to arbitration
   output logic [7:0] intBid,
   output logic [7:0] intStatus
);
   // ==================================================================
   // state
   dct_pkg::dct_dev_state_t s_r, s_nxt;
   logic sel, rd, wr, doStart, doStop, pinRise, pin16, x116, ctTick, ctSet, cosTick;
   logic [3:0] ofs;
   logic [15:0] preset;

   // status assembly, live inputs mixed with stored bits
   always_comb begin
      intStatus[`DCT_ST_TXA] = s_r.statTx[0];
      intStatus[`DCT_ST_RXA] = rxReady[0];
      intStatus[`DCT_ST_BRKA] = s_r.brk[0];
      intStatus[`DCT_ST_CTR] = s_r.ctReady;
      intStatus[`DCT_ST_TXB] = s_r.statTx[1];
      intStatus[`DCT_ST_RXB] = rxReady[1];
      intStatus[`DCT_ST_BRKB] = s_r.brk[1];
      intStatus[`DCT_ST_COS] = |(s_r.cosFlag & s_r.aux[3:0]);
   end

   // mask only gates the bid, never the stored or read status
   assign intBid = intStatus & s_r.mask;
   assign bus.rdata = s_r.rdata;
   // only io1b can carry the counter output; other driven pins sit high
   assign ioOut = {s_r.ctOut, 3'b111};
   assign ioOe = s_r.pinOe;

   // ==================================================================
   // next-state logic
   always_comb begin
      s_nxt = s_r;
      // two-flop synchronisers on the pins, read whatever their direction
      s_nxt.sync1 = ioIn;
      s_nxt.sync2 = s_r.sync1;
      ofs = bus.addr[3:0];
      sel = bus.addr[4] == PAIR;
      rd = bus.rdEn & sel;
      wr = bus.wrEn & sel;
      doStart = rd && ofs == `DCT_OFS_START;
      doStop = rd && ofs == `DCT_OFS_STOP;
      preset = {s_r.presetHi, s_r.presetLo};

      // clock sources for the counter/timer
      s_nxt.x1Div = s_r.x1Div + 4'h1;
      x116 = s_r.x1Div == 4'hF;
      s_nxt.pinPrev = s_r.sync2[1];
      pinRise = s_r.sync2[1] & ~s_r.pinPrev;
      pin16 = pinRise && s_r.pinDiv == 4'hF;
      if (pinRise) begin
         s_nxt.pinDiv = s_r.pinDiv + 4'h1;
      end
      unique case (s_r.aux[6:4])
         3'b000, 3'b100: ctTick = pinRise;
         3'b001: ctTick = txClkA;
         3'b010: ctTick = txClkB;
         3'b101: ctTick = pin16;
         3'b110: ctTick = 1'b1;
         3'b011, 3'b111: ctTick = x116;
      endcase

      // counter/timer
      ctSet = 1'b0;
      if (s_r.aux[6]) begin
         // timer: reload per half-period so a new preset waits for the next one
         if (doStart) begin
            s_nxt.cnt = preset;
            s_nxt.ctOut = 1'b1;
            s_nxt.running = 1'b1;
         end else if (s_r.running && ctTick) begin
            if (s_r.cnt <= 16'h0001) begin
               s_nxt.cnt = preset;
               s_nxt.ctOut = ~s_r.ctOut;
               ctSet = ~s_r.ctOut;
            end else begin
               s_nxt.cnt = s_r.cnt - 16'h0001;
            end
         end
         if (doStop) begin
            s_nxt.ctReady = 1'b0;
         end
      end else begin
         if (doStart) begin
            s_nxt.cnt = preset;
            s_nxt.running = 1'b1;
            s_nxt.ctOut = 1'b1;
         end else if (doStop) begin
            s_nxt.running = 1'b0;
            s_nxt.ctOut = 1'b1;
            s_nxt.ctReady = 1'b0;
         end else if (s_r.running && ctTick) begin
            // zero wraps to ffff by itself
            s_nxt.cnt = s_r.cnt - 16'h0001;
            if (s_r.cnt == 16'h0001) begin
               ctSet = 1'b1;
               s_nxt.ctOut = 1'b0;
            end
         end
      end
      if (ctSet) begin
         s_nxt.ctReady = 1'b1;
      end

      // transmitter ready, blanked for a cycle after each write
      s_nxt.txBlank = txWrite;
      s_nxt.statTx = txFillOk & ~txOff & ~txWrite & ~s_r.txBlank;

      // break change: an edge in the clearing cycle still sets
      for (int i = 0; i < 2; i++) begin
         if (wr && ofs == `DCT_OFS_CMD && bus.wdata[i]) begin
            s_nxt.brk[i] = 1'b0;
         end
         if (breakEdge[i]) begin
            s_nxt.brk[i] = 1'b1;
         end
      end

      // change detectors
      cosTick = s_r.cosDiv == 10'(`DCT_COS_DIV - 1);
      s_nxt.cosDiv = cosTick ? 10'h000 : s_r.cosDiv + 10'h001;
      if (rd && ofs == `DCT_OFS_CHANGE) begin
         s_nxt.cosFlag = 4'h0;
      end
      if (cosTick) begin
         for (int i = 0; i < 4; i++) begin
            if (s_r.sync2[i] != s_r.cosStable[i]) begin
               // second differing sample in a row confirms the change
               if (s_r.cosPend[i]) begin
                  s_nxt.cosStable[i] = s_r.sync2[i];
                  s_nxt.cosFlag[i] = 1'b1;
                  s_nxt.cosPend[i] = 1'b0;
               end else begin
                  s_nxt.cosPend[i] = 1'b1;
               end
            end else begin
               s_nxt.cosPend[i] = 1'b0;
            end
         end
      end

      // register writes; preset bytes have no read path
      if (wr) begin
         unique case (ofs)
            `DCT_OFS_MASK: s_nxt.mask = bus.wdata;
            `DCT_OFS_PRESET_HI: s_nxt.presetHi = bus.wdata;
            `DCT_OFS_PRESET_LO: s_nxt.presetLo = bus.wdata;
            `DCT_OFS_AUX: s_nxt.aux = bus.wdata;
            `DCT_OFS_PINOE: s_nxt.pinOe = bus.wdata[3:0];
            default: ;
         endcase
      end

      // register reads, captured for the next cycle
      if (rd) begin
         unique case (ofs)
            `DCT_OFS_STATUS: s_nxt.rdata = intStatus;
            `DCT_OFS_MASK: s_nxt.rdata = s_r.mask;
            `DCT_OFS_PRESET_HI: s_nxt.rdata = s_r.cnt[15:8];
            `DCT_OFS_PRESET_LO: s_nxt.rdata = s_r.cnt[7:0];
            `DCT_OFS_AUX: s_nxt.rdata = s_r.aux;
            `DCT_OFS_CHANGE: s_nxt.rdata = {s_r.cosFlag, s_r.sync2};
            `DCT_OFS_PINOE: s_nxt.rdata = {4'h0, s_r.pinOe};
            default: s_nxt.rdata = 8'h00;
         endcase
      end
   end

   // ==================================================================
   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.presetHi <= `DCT_RST_PRESET_HI;
         s_r.presetLo <= `DCT_RST_PRESET_LO;
         s_r.mask <= `DCT_RST_MASK;
         s_r.aux <= `DCT_RST_AUX;
         s_r.pinOe <= 4'h0;
         s_r.ctOut <= 1'b1;
         s_r.ctReady <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// ### verilog/dct_host.sv
// host controller: AXI4-Lite command port driving the parallel register bus
`timescale 1ns/1ps
`include "dct_defs.svh"
module dct_host (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register bus
   dct_bus_if.host bus
);
   // ==================================================================
   // state
   dct_pkg::dct_host_state_t s_r, s_nxt;
   logic busy, cmdWr;
   logic [5:0] cmdAddr;
   logic [7:0] cmdData;

   assign busy = s_r.st != dct_pkg::HS_IDLE;
   assign s_axi_awready = ~s_r.awHave;
   assign s_axi_wready = ~s_r.wHave;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = ~s_r.rvalid;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign bus.addr = s_r.busAddr;
   assign bus.wdata = s_r.busWdata;
   assign bus.wrEn = s_r.st == dct_pkg::HS_STROBE && s_r.busWr;
   assign bus.rdEn = s_r.st == dct_pkg::HS_STROBE && !s_r.busWr;

   // ==================================================================
   // next-state logic
   always_comb begin
      s_nxt = s_r;
      cmdWr = s_r.wData[`DCT_HCMD_WR];
      cmdAddr = s_r.wData[13:8];
      cmdData = s_r.wData[7:0];
      // address and data taken independently, in either order
      if (s_axi_awvalid && !s_r.awHave) begin
         s_nxt.awHave = 1'b1;
         s_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.wHave) begin
         s_nxt.wHave = 1'b1;
         s_nxt.wData = s_axi_wdata;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // a command while busy or to an unmapped word answers slverr
      if (s_r.awHave && s_r.wHave && !s_r.bvalid) begin
         s_nxt.awHave = 1'b0;
         s_nxt.wHave = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = `DCT_RESP_SLVERR;
         if (s_r.awAddr == `DCT_HOFS_CMD && !busy) begin
            s_nxt.bresp = `DCT_RESP_OKAY;
            s_nxt.refused = 1'b0;
            s_nxt.tornWarn = 1'b0;
            s_nxt.busAddr = cmdAddr;
            s_nxt.busWr = cmdWr;
            s_nxt.busWdata = cmdData;
            s_nxt.st = dct_pkg::HS_STROBE;
            if (cmdWr && cmdAddr[3:0] == `DCT_OFS_PRESET_HI) begin
               s_nxt.upperZero = cmdData == 8'h00;
            end
            // a lower preset byte below two, written while the last upper byte was zero, never reaches the device
            if (cmdWr && cmdAddr[3:0] == `DCT_OFS_PRESET_LO && s_r.upperZero &&
               cmdData < `DCT_MIN_PRESET) begin
               s_nxt.refused = 1'b1;
               s_nxt.st = dct_pkg::HS_IDLE;
            end
            if (!cmdWr && cmdAddr[3:0] == `DCT_OFS_START) begin
               s_nxt.ctStopped = 1'b0;
            end
            if (!cmdWr && cmdAddr[3:0] == `DCT_OFS_STOP) begin
               s_nxt.ctStopped = 1'b1;
            end
            // live count read while running may be torn by a carry
            if (!cmdWr && !s_r.ctStopped && (cmdAddr[3:0] == `DCT_OFS_PRESET_HI ||
               cmdAddr[3:0] == `DCT_OFS_PRESET_LO)) begin
               s_nxt.tornWarn = 1'b1;
            end
         end
      end
      // reads of the controller's own registers
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_r.rvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = `DCT_RESP_OKAY;
         s_nxt.rdata = 32'h0000_0000;
         if (s_axi_araddr == `DCT_HOFS_STAT) begin
            s_nxt.rdata = {21'h000000, s_r.tornWarn, s_r.refused, busy, s_r.lastRead};
         end else if (s_axi_araddr == `DCT_HOFS_CMD) begin
            s_nxt.rdata = s_r.wData;
         end else begin
            s_nxt.rresp = `DCT_RESP_SLVERR;
         end
      end
      // bus sequencer
      unique case (s_r.st)
         dct_pkg::HS_IDLE: ;
         dct_pkg::HS_STROBE: s_nxt.st = s_r.busWr ? dct_pkg::HS_IDLE : dct_pkg::HS_CAPT;
         dct_pkg::HS_CAPT: begin
            s_nxt.lastRead = bus.rdata;
            s_nxt.st = dct_pkg::HS_IDLE;
         end
         default: s_nxt.st = dct_pkg::HS_IDLE;
      endcase
   end

   // ==================================================================
   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.st <= dct_pkg::HS_IDLE;
         s_r.ctStopped <= 1'b1;
         // device upper preset byte resets to zero, so a small lower byte is refused
         s_r.upperZero <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// ### verilog/dct_pkg.sv
// types shared by both ends of the counter/status block
package dct_pkg;
   // ==================================================================
   // device end state
   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [1:0] statTx;
      logic [1:0] txBlank;
      logic [1:0] brk;
      logic [7:0] mask;
      logic [7:0] presetHi;
      logic [7:0] presetLo;
      logic [7:0] aux;
      logic [3:0] pinOe;
      logic [15:0] cnt;
      logic running;
      logic ctReady;
      logic ctOut;
      logic pinPrev;
      logic [3:0] pinDiv;
      logic [3:0] x1Div;
      logic [9:0] cosDiv;
      logic [3:0] cosStable;
      logic [3:0] cosPend;
      logic [3:0] cosFlag;
      logic [7:0] rdata;
   } dct_dev_state_t;

   // ==================================================================
   // host end sequencer
   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_STROBE = 3'b010,
      HS_CAPT = 3'b100
   } dct_host_st_t;

   typedef struct packed {
      dct_host_st_t st;
      logic awHave;
      logic [3:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [5:0] busAddr;
      logic busWr;
      logic [7:0] busWdata;
      logic [7:0] lastRead;
      logic upperZero;
      logic ctStopped;
      logic refused;
      logic tornWarn;
   } dct_host_state_t;
endpackage
